// >>> pkg/fsk_reload_pkg.sv
// Constants shared by the frequency-shift reload block
package fsk_reload_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned COEF_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RELOAD_CTRL = 8'h20;
  localparam logic [7:0] IDX_SPACE_AMP = 8'h63;
  localparam logic [7:0] IDX_SPACE_FREQ = 8'h64;
  localparam logic [7:0] IDX_MARK_AMP = 8'h65;
  localparam logic [7:0] IDX_MARK_FREQ = 8'h66;
  localparam logic [7:0] IDX_S2M_GAIN = 8'h67;
  localparam logic [7:0] IDX_M2S_GAIN = 8'h68;
  localparam logic [7:0] IDX_STATUS = 8'h69;
  localparam logic [7:0] IDX_FEATURE_CTRL = 8'h6c;

  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 8;

  // Enable bit position in both control registers
  localparam int unsigned EN_BIT = 6;

  // Status register fields
  localparam int unsigned ST_MODE_BIT = 0;
  localparam int unsigned ST_SYM_BIT = 1;
  localparam int unsigned ST_HIST_BIT = 2;

  localparam logic [COEF_W-1:0] COEF_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Gain factors are unsigned Q1.15: 16'h8000 is unity
  localparam int unsigned GAIN_FRAC = 15;
  localparam logic [COEF_W-1:0] COEF_MAX = 16'hffff;

  typedef enum logic [1:0] {
    SYM_NONE = 2'b00,
    SYM_S2M = 2'b01,
    SYM_M2S = 2'b10
  } transition_t;

endpackage

// >>> rtl/fsk_reload.sv
// Frequency-shift keying reload and transition gain for tone oscillator 1
//
// Overview of operation
// - Shift-keying mode runs only while both the feature enable bit and the reload enable bit are one.
// - In that mode a timer expiry for a space loads the space amplitude coefficient in place of the normal one.
// - In that mode a timer expiry for a space loads the space frequency coefficient in place of the normal one.
// - In that mode a timer expiry for a mark loads the mark amplitude coefficient in place of the normal one.
// - In that mode a timer expiry for a mark loads the mark frequency coefficient in place of the normal one.
// - In that mode a change from space to mark scales the amplitude by the space-to-mark gain factor.
// - In that mode a change from mark to space scales the amplitude by the mark-to-space gain factor.
`timescale 1ns/100ps
`default_nettype none

module fsk_reload
  import fsk_reload_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Oscillator 1 side, same clock
  input wire logic normal_frequency_a_active_timer_i,
  input wire logic tx_symbol_i,
  input wire logic [COEF_W-1:0] normal_frequency_a_normal_amplitude_i,
  input wire logic [COEF_W-1:0] normal_frequency_a_i,
  output logic normal_frequency_a_load_o,
  output logic [COEF_W-1:0] normal_frequency_a_amplitude_o,
  output logic [COEF_W-1:0] normal_frequency_a_frequency_o,
  output logic shift_keying_active_o
);

  logic [COEF_W-1:0] space_amplitude_coeff_reg;
  logic [COEF_W-1:0] space_frequency_coeff_reg;
  logic [COEF_W-1:0] mark_amplitude_coeff_reg;
  logic [COEF_W-1:0] mark_frequency_coeff_reg;
  logic [COEF_W-1:0] space_to_mark_gain_reg;
  logic [COEF_W-1:0] mark_to_space_gain_reg;
  logic shift_keying_enable_reg;
  logic oscillator_reload_enable_reg;
  logic last_symbol_reg;
  logic history_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic load_reg;
  logic [COEF_W-1:0] amp_reg;
  logic [COEF_W-1:0] freq_reg;
  logic active_reg;

  logic [IDX_W-1:0] idx;
  logic mapped;
  logic access_done;
  logic wr_en;
  logic mode_on;
  transition_t transition;
  logic [COEF_W-1:0] base_amp;
  logic [COEF_W-1:0] scaled_amp;
  logic [COEF_W-1:0] amp_next;
  logic [COEF_W-1:0] freq_next;
  logic [DATA_W-1:0] read_word;

  // Unsigned Q1.15 product, saturated so a gain above unity cannot wrap
  function automatic logic [COEF_W-1:0] apply_gain(input logic [COEF_W-1:0] coef,
                                                   input logic [COEF_W-1:0] gain);
    logic [2*COEF_W-1:0] prod;
    prod = coef * gain;
    if (prod[2*COEF_W-1]) begin
      apply_gain = COEF_MAX;
    end else begin
      apply_gain = prod[GAIN_FRAC +: COEF_W];
    end
  endfunction

  // ---------------- APB decode ----------------
  // Address bits above the index are ignored, so the map aliases every 1 KB
  assign idx = paddr_i[IDX_LSB +: IDX_W];
  assign access_done = psel_i && penable_i && pready_reg;
  assign wr_en = access_done && pwrite_i && mapped;

  always_comb begin
    mapped = 1'b1;
    read_word = RDATA_ZERO;
    unique case (idx)
      IDX_SPACE_AMP: read_word[COEF_W-1:0] = space_amplitude_coeff_reg;
      IDX_SPACE_FREQ: read_word[COEF_W-1:0] = space_frequency_coeff_reg;
      IDX_MARK_AMP: read_word[COEF_W-1:0] = mark_amplitude_coeff_reg;
      IDX_MARK_FREQ: read_word[COEF_W-1:0] = mark_frequency_coeff_reg;
      IDX_S2M_GAIN: read_word[COEF_W-1:0] = space_to_mark_gain_reg;
      IDX_M2S_GAIN: read_word[COEF_W-1:0] = mark_to_space_gain_reg;
      IDX_FEATURE_CTRL: read_word[EN_BIT] = shift_keying_enable_reg;
      IDX_RELOAD_CTRL: read_word[EN_BIT] = oscillator_reload_enable_reg;
      IDX_STATUS: begin
        read_word[ST_MODE_BIT] = mode_on;
        read_word[ST_SYM_BIT] = last_symbol_reg;
        read_word[ST_HIST_BIT] = history_reg;
      end
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle, then drops
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RDATA_ZERO;
    end else if (psel_i && penable_i && !pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !mapped || (pwrite_i && idx == IDX_STATUS);
      prdata_reg <= pwrite_i ? RDATA_ZERO : read_word;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RDATA_ZERO;
    end
  end

  // ---------------- Register file ----------------
  // Only the low half of a write is kept; the upper half always reads back as zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      space_amplitude_coeff_reg <= COEF_RESET;
      space_frequency_coeff_reg <= COEF_RESET;
      mark_amplitude_coeff_reg <= COEF_RESET;
      mark_frequency_coeff_reg <= COEF_RESET;
      space_to_mark_gain_reg <= COEF_RESET;
      mark_to_space_gain_reg <= COEF_RESET;
    end else if (wr_en) begin
      unique case (idx)
        IDX_SPACE_AMP: space_amplitude_coeff_reg <= pwdata_i[COEF_W-1:0];
        IDX_SPACE_FREQ: space_frequency_coeff_reg <= pwdata_i[COEF_W-1:0];
        IDX_MARK_AMP: mark_amplitude_coeff_reg <= pwdata_i[COEF_W-1:0];
        IDX_MARK_FREQ: mark_frequency_coeff_reg <= pwdata_i[COEF_W-1:0];
        IDX_S2M_GAIN: space_to_mark_gain_reg <= pwdata_i[COEF_W-1:0];
        IDX_M2S_GAIN: mark_to_space_gain_reg <= pwdata_i[COEF_W-1:0];
        default: ;
      endcase
    end
  end

  // Each enable is one bit of its own control word; the rest of those words reads as zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_keying_enable_reg <= 1'b0;
      oscillator_reload_enable_reg <= 1'b0;
    end else if (wr_en) begin
      if (idx == IDX_FEATURE_CTRL) begin
        shift_keying_enable_reg <= pwdata_i[EN_BIT];
      end
      if (idx == IDX_RELOAD_CTRL) begin
        oscillator_reload_enable_reg <= pwdata_i[EN_BIT];
      end
    end
  end

  // ---------------- Reload path ----------------
  assign mode_on = shift_keying_enable_reg && oscillator_reload_enable_reg;

  // A correction needs an earlier expiry in this mode; the first symbol after entry goes out unscaled
  always_comb begin
    transition = SYM_NONE;
    if (mode_on && history_reg && last_symbol_reg != tx_symbol_i) begin
      transition = tx_symbol_i ? SYM_S2M : SYM_M2S;
    end
  end

  // Both words follow one symbol so amplitude and frequency never come from different sets
  always_comb begin
    base_amp = normal_frequency_a_normal_amplitude_i;
    freq_next = normal_frequency_a_i;
    if (mode_on && !tx_symbol_i) begin
      base_amp = space_amplitude_coeff_reg;
      freq_next = space_frequency_coeff_reg;
    end else if (mode_on) begin
      base_amp = mark_amplitude_coeff_reg;
      freq_next = mark_frequency_coeff_reg;
    end
  end

  always_comb begin
    unique case (transition)
      SYM_S2M: scaled_amp = apply_gain(base_amp, space_to_mark_gain_reg);
      SYM_M2S: scaled_amp = apply_gain(base_amp, mark_to_space_gain_reg);
      SYM_NONE: scaled_amp = base_amp;
      default: scaled_amp = base_amp;
    endcase
    amp_next = scaled_amp;
  end

  // Symbol history is dropped outside the mode so re-entry starts without a correction
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_symbol_reg <= 1'b0;
      history_reg <= 1'b0;
    end else if (!mode_on) begin
      history_reg <= 1'b0;
    end else if (normal_frequency_a_active_timer_i) begin
      last_symbol_reg <= tx_symbol_i;
      history_reg <= 1'b1;
    end
  end

  // Registered so the oscillator sees a settled word one cycle after its own expiry
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_reg <= 1'b0;
      amp_reg <= COEF_RESET;
      freq_reg <= COEF_RESET;
    end else begin
      load_reg <= normal_frequency_a_active_timer_i;
      if (normal_frequency_a_active_timer_i) begin
        amp_reg <= amp_next;
        freq_reg <= freq_next;
      end
    end
  end

  // Lags the enables by one cycle; software polling it sees the settled mode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= mode_on;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign normal_frequency_a_load_o = load_reg;
  assign normal_frequency_a_amplitude_o = amp_reg;
  assign normal_frequency_a_frequency_o = freq_reg;
  assign shift_keying_active_o = active_reg;

  // ---------------- Assertions ----------------
  logic expire_plain;
  logic [COEF_W-1:0] s2m_expect;
  logic [COEF_W-1:0] m2s_expect;
  // Expected products apply the same saturating gain to the opposite symbol's amplitude
  assign expire_plain = normal_frequency_a_active_timer_i && transition == SYM_NONE;
  assign s2m_expect = apply_gain(mark_amplitude_coeff_reg, space_to_mark_gain_reg);
  assign m2s_expect = apply_gain(space_amplitude_coeff_reg, mark_to_space_gain_reg);

  a_mode_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    shift_keying_active_o |-> $past(shift_keying_enable_reg) && $past(oscillator_reload_enable_reg))
    else $error("Mode active without both enables");

  a_space_amp_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    expire_plain && mode_on && !tx_symbol_i |=> normal_frequency_a_load_o && normal_frequency_a_amplitude_o == $past(space_amplitude_coeff_reg))
    else $error("Space amplitude not loaded");

  a_space_freq_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && mode_on && !tx_symbol_i |=> normal_frequency_a_frequency_o == $past(space_frequency_coeff_reg))
    else $error("Space frequency not loaded");

  a_mark_amp_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    expire_plain && mode_on && tx_symbol_i |=> normal_frequency_a_amplitude_o == $past(mark_amplitude_coeff_reg))
    else $error("Mark amplitude not loaded");

  a_mark_freq_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && mode_on && tx_symbol_i |=> normal_frequency_a_frequency_o == $past(mark_frequency_coeff_reg))
    else $error("Mark frequency not loaded");

  a_s2m_gain: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && mode_on && history_reg && !last_symbol_reg && tx_symbol_i
    |=> normal_frequency_a_amplitude_o == $past(s2m_expect))
    else $error("Space to mark gain not applied");

  a_m2s_gain: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && mode_on && history_reg && last_symbol_reg && !tx_symbol_i
    |=> normal_frequency_a_amplitude_o == $past(m2s_expect))
    else $error("Mark to space gain not applied");

  a_normal_reload: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && !mode_on
    |=> normal_frequency_a_amplitude_o == $past(normal_frequency_a_normal_amplitude_i) && normal_frequency_a_frequency_o == $past(normal_frequency_a_i))
    else $error("Normal coefficients not reloaded");

  a_history_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !mode_on |=> !history_reg)
    else $error("Symbol history kept outside mode");

  a_apb_answer: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("APB answer not one wait state");

  a_pready_source: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    pready_o |-> $past(psel_i) && $past(penable_i))
    else $error("Ready without an access phase");

  // An error answer must never carry stale read data
  a_apb_error: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    psel_i && penable_i && !pready_o && !mapped |=> pready_o && pslverr_o && prdata_o == RDATA_ZERO)
    else $error("Unmapped access not refused");

  a_status_write: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    psel_i && penable_i && !pready_o && pwrite_i && idx == IDX_STATUS |=> pslverr_o)
    else $error("Status write not refused");

  a_prdata_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !pready_o |-> prdata_o == RDATA_ZERO && !pslverr_o)
    else $error("Read data or error outside answer cycle");

  a_mode_drop: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    wr_en && !pwdata_i[EN_BIT] && (idx == IDX_FEATURE_CTRL || idx == IDX_RELOAD_CTRL) |=> !mode_on)
    else $error("Mode still on after an enable was cleared");

  a_load_strobe: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i |=> normal_frequency_a_load_o)
    else $error("Load strobe missing after expiry");

  a_load_single: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !normal_frequency_a_active_timer_i |=> !normal_frequency_a_load_o)
    else $error("Load strobe without expiry");

  // Words must hold between expiries or the oscillator would glitch mid-tone
  a_coef_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !normal_frequency_a_active_timer_i |=> $stable(normal_frequency_a_amplitude_o) && $stable(normal_frequency_a_frequency_o))
    else $error("Coefficients changed without expiry");

  a_history_track: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && mode_on |=> history_reg && last_symbol_reg == $past(tx_symbol_i))
    else $error("Symbol history not updated");

  c_s2m_seen: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && transition == SYM_S2M);
  c_m2s_seen: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && transition == SYM_M2S);
  c_normal_seen: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    normal_frequency_a_active_timer_i && !mode_on);
  c_bad_addr: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    pready_o && pslverr_o);
  c_mode_entry: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(shift_keying_active_o));

endmodule

`default_nettype wire

// >>> verification/fsk_reload_tb_top.sv
// Self-checking testbench for the frequency-shift reload block
`timescale 1ns/100ps
`default_nettype none

module fsk_reload_tb_top
  import fsk_reload_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic tmr = 1'b0;
  logic symb = 1'b0;
  logic [COEF_W-1:0] norm_amp = 16'h0aa0;
  logic [COEF_W-1:0] norm_freq = 16'h0bb0;
  logic load;
  logic [COEF_W-1:0] amp;
  logic [COEF_W-1:0] freq;
  logic active;
  int mismatches = 0;
  int n_tests = 0;

  always #2.5 clk = ~clk;

  fsk_reload u_dut (
    .core_clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .normal_frequency_a_active_timer_i(tmr), .tx_symbol_i(symb), .normal_frequency_a_normal_amplitude_i(norm_amp),
    .normal_frequency_a_i(norm_freq), .normal_frequency_a_load_o(load), .normal_frequency_a_amplitude_o(amp),
    .normal_frequency_a_frequency_o(freq), .shift_keying_active_o(active)
  );

  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pready is polled at each rising edge, so the answer is taken at the very edge the slave completes on
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    @(posedge clk);
    while (pready !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (pready !== 1'b1) begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic expire(input logic sym, input logic [15:0] ea, input logic [15:0] ef);
    @(posedge clk);
    tmr <= 1'b1;
    symb <= sym;
    @(posedge clk);
    tmr <= 1'b0;
    @(negedge clk);
    cmp({31'h0, load}, 32'h1);
    cmp({16'h0, amp}, {16'h0, ea});
    cmp({16'h0, freq}, {16'h0, ef});
    @(negedge clk);
    cmp({31'h0, load}, 32'h0);
    cmp({16'h0, amp}, {16'h0, ea});
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    logic [15:0] v [6] = '{16'h2000, 16'h1111, 16'h1234, 16'h2222, 16'h4000, 16'hc000};
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, IDX_SPACE_AMP + 8'(k), 32'h0, rd, err);
      cmp(rd, 32'h0);
      apb(1'b1, IDX_SPACE_AMP + 8'(k), {16'hffff, v[k]}, rd, err);
      apb(1'b0, IDX_SPACE_AMP + 8'(k), 32'h0, rd, err);
      cmp(rd, {16'h0, v[k]});
      cmp({31'h0, err}, 32'h0);
    end
    apb(1'b0, 8'h70, 32'h0, rd, err);
    cmp({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, IDX_STATUS, 32'hffff_ffff, rd, err);
    cmp({31'h0, err}, 32'h1);
  endtask

  task automatic t_mode_off();
    logic [31:0] rd;
    logic err;
    apb(1'b1, IDX_FEATURE_CTRL, 32'h40, rd, err);
    @(negedge clk);
    cmp({31'h0, active}, 32'h0);
    expire(1'b0, 16'h0aa0, 16'h0bb0);
    expire(1'b1, 16'h0aa0, 16'h0bb0);
  endtask

  task automatic t_mode_on();
    logic [31:0] rd;
    logic err;
    apb(1'b1, IDX_RELOAD_CTRL, 32'h40, rd, err);
    @(posedge clk);
    @(negedge clk);
    cmp({31'h0, active}, 32'h1);
    apb(1'b0, IDX_STATUS, 32'h0, rd, err);
    cmp(rd, 32'h1);
    apb(1'b0, IDX_RELOAD_CTRL, 32'h0, rd, err);
    cmp(rd, 32'h40);
    apb(1'b0, IDX_FEATURE_CTRL, 32'h0, rd, err);
    cmp(rd, 32'h40);
    expire(1'b0, 16'h2000, 16'h1111);
    expire(1'b1, 16'h091a, 16'h2222);
    expire(1'b1, 16'h1234, 16'h2222);
    expire(1'b0, 16'h3000, 16'h1111);
    apb(1'b0, IDX_STATUS, 32'h0, rd, err);
    cmp(rd, 32'h5);
    apb(1'b1, IDX_FEATURE_CTRL, 32'h0, rd, err);
    expire(1'b1, 16'h0aa0, 16'h0bb0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_mode_off();
    t_mode_on();
    test_done();
  end
endmodule

`default_nettype wire
